//--- hdl/tdp_cfg.svh
// constants of the dual-port memory block
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH
`define TDP_CELLS 4096
`define TDP_CELL_AW 12
`define TDP_CHUNKS 16
`define TDP_CHUNK_BITS 256
`define TDP_CHUNK_SLACK 4
`define TDP_MAX_WIDTH 16
`define TDP_OFF_CTRL 4'h0
`define TDP_OFF_STATUS 4'h4
`define TDP_OFF_CONFL 4'h8
`define TDP_OFF_SHAPE 4'hC
`define TDP_INV_CLK 0
`define TDP_INV_EN 1
`define TDP_INV_WE 2
`define TDP_INV_CLR 3
`define TDP_CTRL_FIRST 0
`define TDP_CTRL_SECOND 4
`define TDP_ST_WW 0
`define TDP_ST_RB_FIRST 1
`define TDP_ST_RB_SECOND 2
`define TDP_ST_W 3
`define TDP_CNT_W 16
`define TDP_SHAPE_SECOND 8
`define TDP_INV_RESET 8'h00
`endif

//--- hdl/tdp_mem.sv
// shared cell array with per-port output latches
`timescale 1ns/100ps
`include "tdp_cfg.svh"
module tdp_mem #(
  parameter int WIDTH_FIRST = `TDP_MAX_WIDTH,
  parameter int WIDTH_SECOND = `TDP_MAX_WIDTH,
  parameter logic [`TDP_CHUNK_BITS+`TDP_CHUNK_SLACK-1:0] PRELOAD [`TDP_CHUNKS] = '{default: '0}
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic act_first_i,
  input wire logic wr_first_i,
  input wire logic clr_first_i,
  input wire tdp_pkg::tdp_cell_t base_first_i,
  input wire logic [WIDTH_FIRST-1:0] din_first_i,
  input wire logic rbad_first_i,
  input wire logic act_second_i,
  input wire logic wr_second_i,
  input wire logic clr_second_i,
  input wire tdp_pkg::tdp_cell_t base_second_i,
  input wire logic [WIDTH_SECOND-1:0] din_second_i,
  input wire logic rbad_second_i,
  input wire logic ww_i,
  output logic [WIDTH_FIRST-1:0] dout_first_o,
  output logic bad_first_o,
  output logic [WIDTH_SECOND-1:0] dout_second_o,
  output logic bad_second_o
);
  localparam logic [`TDP_CELL_AW:0] WF = (`TDP_CELL_AW+1)'(WIDTH_FIRST);
  localparam logic [`TDP_CELL_AW:0] WS = (`TDP_CELL_AW+1)'(WIDTH_SECOND);

  function automatic logic [`TDP_CELLS-1:0] preload_image();
    logic [`TDP_CELLS-1:0] img;
    img = '0;
    for (int n = 0; n < `TDP_CHUNKS; n++) begin
      img[n*`TDP_CHUNK_BITS +: `TDP_CHUNK_BITS] = PRELOAD[n][`TDP_CHUNK_BITS-1:0];
    end
    return img;
  endfunction

  function automatic logic in_range(input tdp_pkg::tdp_cell_t c, input tdp_pkg::tdp_cell_t b,
                                    input logic [`TDP_CELL_AW:0] w);
    return ({1'b0, c} >= {1'b0, b}) && ({1'b0, c} < {1'b0, b} + w);
  endfunction

  localparam logic [`TDP_CELLS-1:0] PRE_IMG = preload_image();

  // an over-long preload value stops elaboration instead of being cut
  for (genvar n = 0; n < `TDP_CHUNKS; n++) begin : g_chk
    if (PRELOAD[n][`TDP_CHUNK_BITS+`TDP_CHUNK_SLACK-1:`TDP_CHUNK_BITS] != '0) begin : g_bad
      $error("preload value longer than 64 hex digits");
    end
  end

  logic [`TDP_CELLS-1:0] mem_q;
  logic [`TDP_CELLS-1:0] mem_d;
  logic [`TDP_CELLS-1:0] pois_q;
  logic [`TDP_CELLS-1:0] pois_d;
  logic [WIDTH_FIRST-1:0] dout_first_d;
  logic [WIDTH_SECOND-1:0] dout_second_d;
  logic bad_first_d;
  logic bad_second_d;
  tdp_pkg::tdp_cell_t c;

  always_comb begin
    mem_d = mem_q;
    pois_d = pois_q;
    c = '0;
    // cells are addressed lowest bit first
    for (int i = 0; i < WIDTH_FIRST; i++) begin
      c = base_first_i + `TDP_CELL_AW'(i);
      if (wr_first_i) begin
        mem_d[c] = din_first_i[i];
        pois_d[c] = ww_i && in_range(c, base_second_i, WS);
      end
    end
    for (int i = 0; i < WIDTH_SECOND; i++) begin
      c = base_second_i + `TDP_CELL_AW'(i);
      if (wr_second_i) begin
        mem_d[c] = din_second_i[i];
        pois_d[c] = ww_i && in_range(c, base_first_i, WF);
      end
    end
    dout_first_d = dout_first_o;
    bad_first_d = bad_first_o;
    if (clr_first_i) begin
      dout_first_d = '0;
      bad_first_d = 1'b0;
    end else if (wr_first_i) begin
      dout_first_d = din_first_i;
      bad_first_d = 1'b0;
    end else if (act_first_i) begin
      dout_first_d = mem_q[base_first_i +: WIDTH_FIRST];
      bad_first_d = rbad_first_i | (|pois_q[base_first_i +: WIDTH_FIRST]);
    end
    dout_second_d = dout_second_o;
    bad_second_d = bad_second_o;
    if (clr_second_i) begin
      dout_second_d = '0;
      bad_second_d = 1'b0;
    end else if (wr_second_i) begin
      dout_second_d = din_second_i;
      bad_second_d = 1'b0;
    end else if (act_second_i) begin
      dout_second_d = mem_q[base_second_i +: WIDTH_SECOND];
      bad_second_d = rbad_second_i | (|pois_q[base_second_i +: WIDTH_SECOND]);
    end
  end

  // reset stands in for configuration: the array takes its preload image
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_q <= PRE_IMG;
      pois_q <= '0;
      dout_first_o <= '0;
      bad_first_o <= 1'b0;
      dout_second_o <= '0;
      bad_second_o <= 1'b0;
    end else begin
      mem_q <= mem_d;
      pois_q <= pois_d;
      dout_first_o <= dout_first_d;
      bad_first_o <= bad_first_d;
      dout_second_o <= dout_second_d;
      bad_second_o <= bad_second_d;
    end
  end
endmodule

//--- hdl/tdp_pkg.sv
// types of the dual-port memory block
`include "tdp_cfg.svh"
package tdp_pkg;
  typedef enum logic [1:0] {
    TDP_IDLE = 2'h0,
    TDP_ACK = 2'h1
  } tdp_bus_st_t;
  typedef logic [3:0] tdp_inv_t;
  typedef logic [`TDP_CELL_AW-1:0] tdp_cell_t;
endpackage

//--- hdl/tdp_port.sv
// per-port control stage: clock edge and polarity handling
`timescale 1ns/100ps
`include "tdp_cfg.svh"
module tdp_port (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clock_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic clr_i,
  input wire tdp_pkg::tdp_inv_t inv_i,
  output logic act_o,
  output logic wr_o,
  output logic clr_o
);
  logic lvl_q;
  logic lvl_d;
  logic lvl;
  logic edge_seen;
  logic en;

  always_comb begin
    lvl = clock_i ^ inv_i[`TDP_INV_CLK];
    lvl_d = lvl;
    // a port acts only on its own clock edge
    edge_seen = lvl & ~lvl_q;
    en = en_i ^ inv_i[`TDP_INV_EN];
    act_o = edge_seen & en;
    wr_o = act_o & (we_i ^ inv_i[`TDP_INV_WE]);
    clr_o = act_o & (clr_i ^ inv_i[`TDP_INV_CLR]);
  end

  // reset high so a clock idling high gives no false edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvl_q <= 1'b1;
    end else begin
      lvl_q <= lvl_d;
    end
  end
endmodule

//--- hdl/tdp_ram.sv
// true dual-port memory top: ports, conflict check, register slave
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "tdp_cfg.svh"
module tdp_ram #(
  parameter int WIDTH_FIRST = `TDP_MAX_WIDTH,
  parameter int WIDTH_SECOND = `TDP_MAX_WIDTH,
  parameter logic [`TDP_CHUNK_BITS+`TDP_CHUNK_SLACK-1:0] PRELOAD [`TDP_CHUNKS] = '{default: '0},
  parameter logic [7:0] INV_RESET = `TDP_INV_RESET,
  localparam int AW_FIRST = $clog2(`TDP_CELLS / WIDTH_FIRST),
  localparam int AW_SECOND = $clog2(`TDP_CELLS / WIDTH_SECOND)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clock_first_i,
  input wire logic en_first_i,
  input wire logic we_first_i,
  input wire logic clr_first_i,
  input wire logic [AW_FIRST-1:0] addr_first_i,
  input wire logic [WIDTH_FIRST-1:0] in_bus_first_i,
  output logic [WIDTH_FIRST-1:0] out_bus_first_o,
  output logic out_bad_first_o,
  input wire logic clock_second_i,
  input wire logic en_second_i,
  input wire logic we_second_i,
  input wire logic clr_second_i,
  input wire logic [AW_SECOND-1:0] addr_second_i,
  input wire logic [WIDTH_SECOND-1:0] in_bus_second_i,
  output logic [WIDTH_SECOND-1:0] out_bus_second_o,
  output logic out_bad_second_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  localparam int SH_FIRST = $clog2(WIDTH_FIRST);
  localparam int SH_SECOND = $clog2(WIDTH_SECOND);

  function automatic logic width_ok(input int w);
    return w == 1 || w == 2 || w == 4 || w == 8 || w == `TDP_MAX_WIDTH;
  endfunction

  // one cell span overlaps another
  function automatic logic overlap(input tdp_pkg::tdp_cell_t ba, input int wa,
                                   input tdp_pkg::tdp_cell_t bb, input int wb);
    logic [`TDP_CELL_AW:0] a0;
    logic [`TDP_CELL_AW:0] b0;
    a0 = {1'b0, ba};
    b0 = {1'b0, bb};
    return (a0 < b0 + (`TDP_CELL_AW+1)'(wb)) && (b0 < a0 + (`TDP_CELL_AW+1)'(wa));
  endfunction

  if (!width_ok(WIDTH_FIRST) || !width_ok(WIDTH_SECOND)) begin : g_wchk
    $error("port width must be 1, 2, 4, 8 or 16");
  end

  logic act_first;
  logic wr_first;
  logic clr_first;
  logic act_second;
  logic wr_second;
  logic clr_second;
  tdp_pkg::tdp_cell_t base_first;
  tdp_pkg::tdp_cell_t base_second;
  logic clash;
  logic ww;
  logic rbad_first;
  logic rbad_second;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [`TDP_ST_W-1:0] status_q;
  logic [`TDP_ST_W-1:0] status_d;
  logic [`TDP_ST_W-1:0] status_set;
  logic [`TDP_CNT_W-1:0] confl_q;
  logic [`TDP_CNT_W-1:0] confl_d;

  tdp_pkg::tdp_bus_st_t bus_q;
  tdp_pkg::tdp_bus_st_t bus_d;
  logic [31:0] rdata_d;
  logic wait_d;
  logic do_write;

  tdp_port u_port_first (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clock_i(clock_first_i),
    .en_i(en_first_i),
    .we_i(we_first_i),
    .clr_i(clr_first_i),
    .inv_i(ctrl_q[`TDP_CTRL_FIRST +: 4]),
    .act_o(act_first),
    .wr_o(wr_first),
    .clr_o(clr_first)
  );

  tdp_port u_port_second (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clock_i(clock_second_i),
    .en_i(en_second_i),
    .we_i(we_second_i),
    .clr_i(clr_second_i),
    .inv_i(ctrl_q[`TDP_CTRL_SECOND +: 4]),
    .act_o(act_second),
    .wr_o(wr_second),
    .clr_o(clr_second)
  );

  // the setup window is the single system clock cycle: two port edges
  // falling in the same cycle are taken as too close
  always_comb begin
    base_first = `TDP_CELL_AW'(addr_first_i) << SH_FIRST;
    base_second = `TDP_CELL_AW'(addr_second_i) << SH_SECOND;
    clash = act_first && act_second
            && overlap(base_first, WIDTH_FIRST, base_second, WIDTH_SECOND);
    ww = clash && wr_first && wr_second;
    rbad_first = clash && !wr_first && wr_second;
    rbad_second = clash && wr_first && !wr_second;
    status_set = '0;
    status_set[`TDP_ST_WW] = ww;
    status_set[`TDP_ST_RB_FIRST] = rbad_first;
    status_set[`TDP_ST_RB_SECOND] = rbad_second;
  end

  tdp_mem #(
    .WIDTH_FIRST(WIDTH_FIRST),
    .WIDTH_SECOND(WIDTH_SECOND),
    .PRELOAD(PRELOAD)
  ) u_mem (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .act_first_i(act_first),
    .wr_first_i(wr_first),
    .clr_first_i(clr_first),
    .base_first_i(base_first),
    .din_first_i(in_bus_first_i),
    .rbad_first_i(rbad_first),
    .act_second_i(act_second),
    .wr_second_i(wr_second),
    .clr_second_i(clr_second),
    .base_second_i(base_second),
    .din_second_i(in_bus_second_i),
    .rbad_second_i(rbad_second),
    .ww_i(ww),
    .dout_first_o(out_bus_first_o),
    .bad_first_o(out_bad_first_o),
    .dout_second_o(out_bus_second_o),
    .bad_second_o(out_bad_second_o)
  );

  function automatic logic [31:0] reg_read(input logic [3:0] a, input logic [7:0] ctl,
                                           input logic [`TDP_ST_W-1:0] st,
                                           input logic [`TDP_CNT_W-1:0] cnt);
    logic [31:0] r;
    r = '0;
    case (a)
      `TDP_OFF_CTRL: r[7:0] = ctl;
      `TDP_OFF_STATUS: r[`TDP_ST_W-1:0] = st;
      `TDP_OFF_CONFL: r[`TDP_CNT_W-1:0] = cnt;
      `TDP_OFF_SHAPE: begin
        r[7:0] = 8'(WIDTH_FIRST);
        r[`TDP_SHAPE_SECOND +: 8] = 8'(WIDTH_SECOND);
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // slave answers one cycle after the request; the write lands on the
  // edge where the master sees waitrequest low
  always_comb begin
    bus_d = bus_q;
    wait_d = 1'b1;
    rdata_d = avs_readdata_o;
    do_write = 1'b0;
    case (bus_q)
      tdp_pkg::TDP_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          bus_d = tdp_pkg::TDP_ACK;
          wait_d = 1'b0;
          rdata_d = avs_read_i ? reg_read(avs_address_i, ctrl_q, status_q, confl_q) : '0;
        end
      end
      tdp_pkg::TDP_ACK: begin
        bus_d = tdp_pkg::TDP_IDLE;
        do_write = avs_write_i;
      end
      default: begin
        bus_d = tdp_pkg::TDP_IDLE;
      end
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (do_write && avs_address_i == `TDP_OFF_CTRL) begin
      ctrl_d = avs_writedata_i[7:0];
    end
    // a clash in the clearing cycle survives the clear
    status_d = status_q;
    if (do_write && avs_address_i == `TDP_OFF_STATUS) begin
      status_d = status_q & ~avs_writedata_i[`TDP_ST_W-1:0];
    end
    status_d = status_d | status_set;
    confl_d = confl_q;
    if (do_write && avs_address_i == `TDP_OFF_CONFL) begin
      confl_d = '0;
    end
    if (clash && (wr_first || wr_second) && confl_d != '1) begin
      confl_d = confl_d + `TDP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_q <= tdp_pkg::TDP_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
      ctrl_q <= INV_RESET;
      status_q <= '0;
      confl_q <= '0;
    end else begin
      bus_q <= bus_d;
      avs_waitrequest_o <= wait_d;
      avs_readdata_o <= rdata_d;
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      confl_q <= confl_d;
    end
  end
endmodule

//--- verification/tb_true_dual_port_block_ram.sv
// self-checking bench of the dual-port memory
`timescale 1ns/100ps
module tb_true_dual_port_block_ram;
  localparam logic [259:0] PRE [16] = '{0: 260'hFEDC_BA98_7654_3210,
    15: {20'h0C3A5, 240'h0}, default: '0};
  logic clk_i, arst_n_i, clock_first_i, en_first_i, we_first_i, clr_first_i, out_bad_first_o;
  logic clock_second_i, en_second_i, we_second_i, clr_second_i, out_bad_second_o;
  logic [7:0] addr_first_i, in_bus_second_i, out_bus_second_o;
  logic [8:0] addr_second_i;
  logic [15:0] in_bus_first_i, out_bus_first_o;
  logic avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdat, rnd;
  logic [4095:0] img;
  logic [15:0] last [2];
  int error_cnt, comparisons, cyc;
  tdp_ram #(.WIDTH_FIRST(16), .WIDTH_SECOND(8), .PRELOAD(PRE)) tdp_ram_inst (.*);
  tdp_user_port #(.W(16), .AW(8)) user_first (.clk_i(clk_i), .clock_o(clock_first_i),
    .en_o(en_first_i), .we_o(we_first_i), .clr_o(clr_first_i), .addr_o(addr_first_i),
    .din_o(in_bus_first_i));
  tdp_user_port #(.W(8), .AW(9)) user_second (.clk_i(clk_i), .clock_o(clock_second_i),
    .en_o(en_second_i), .we_o(we_second_i), .clr_o(clr_second_i), .addr_o(addr_second_i),
    .din_o(in_bus_second_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // registers straight after reset: only the shape word is nonzero
  function automatic logic [31:0] reg_exp(input logic [3:0] a);
    return (a == 4'hC) ? 32'h0000_0810 : 32'h0;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // one clean access with the expected output worked out from the cell image
  task automatic acc(input bit p, input logic e, w, c, input logic [11:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = p ? 16'h00FF : 16'hFFFF;
    if (p) user_second.op(e, w, c, a, d);
    else user_first.op(e, w, c, a, d);
    if (e && w && p) img[a*8 +: 8] = d[7:0];
    if (e && w && !p) img[a*16 +: 16] = d;
    if (e) last[p] = m & (c ? 16'h0000 : w ? d : p ? 16'(img[a*8 +: 8]) : img[a*16 +: 16]);
    chk("data_out", p ? 16'(out_bus_second_o) : out_bus_first_o, last[p]);
    chk("bad", p ? out_bad_second_o : out_bad_first_o, 1'b0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    {arst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    rnd = 32'hA12AF9B6;
    last = '{16'h0000, 16'h0000};
    for (int n = 0; n < 16; n++) img[256*n +: 256] = PRE[n][255:0];
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    bus(0, 4'hC, 32'h0);
    chk("shape", rdat, 32'h0000_0810);
    bus(0, 4'h6, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      bus(0, rnd[3:0], 32'h0);
      chk("register", rdat, reg_exp(rnd[3:0]));
    end
    $display("test registers done");
    for (int a = 0; a < 512; a += 511) acc(1, 1, 0, 0, a, 0);
    acc(0, 1, 0, 0, 12'h0FF, 0);
    acc(0, 1, 0, 0, 12'h004, 0);
    acc(1, 1, 0, 0, 12'h020, 0);
    for (int i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      acc(rnd[0], rnd[3:1] != 3'h0, rnd[4], rnd[8:5] == 4'h0, 12'(rnd[12:9]) >> !rnd[0], rnd[31:16]);
    end
    $display("test random done");
    acc(0, 1, 0, 0, 5, 0);
    acc(1, 1, 1, 0, 10, 16'h0077);
    chk("hold", out_bus_first_o, last[0]);
    acc(0, 1, 0, 0, 5, 0);
    acc(0, 0, 1, 0, 5, 16'hDEAD);
    acc(0, 1, 0, 0, 5, 0);
    fork
      acc(0, 1, 1, 0, 1, 16'h1357);
      acc(1, 1, 0, 0, 0, 0);
    join
    // same cells, both reading: no clash is counted or flagged
    fork
      acc(0, 1, 0, 0, 1, 0);
      acc(1, 1, 0, 0, 2, 0);
    join
    $display("test ordering done");
    bus(1, 4'h4, 32'h7);
    fork
      user_first.op(1, 1, 0, 6, 16'hAAAA);
      user_second.op(1, 1, 0, 12, 16'h0055);
    join
    chk("ww first", {out_bad_first_o, out_bus_first_o}, 17'h0AAAA);
    chk("ww second", {out_bad_second_o, out_bus_second_o}, 9'h055);
    user_first.op(1, 0, 0, 6, 0);
    chk("poison first", out_bad_first_o, 1'b1);
    user_second.op(1, 0, 0, 12, 0);
    chk("poison second", out_bad_second_o, 1'b1);
    bus(0, 4'h4, 32'h0);
    chk("status ww", rdat[0], 1'b1);
    bus(0, 4'h8, 32'h0);
    chk("conflicts", rdat, 32'h1);
    bus(1, 4'h4, 32'h7);
    acc(0, 1, 1, 0, 6, 16'h2468);
    acc(1, 1, 0, 0, 12, 0);
    $display("test write clash done");
    fork
      user_first.op(1, 1, 0, 7, 16'hBEEF);
      user_second.op(1, 0, 0, 14, 0);
    join
    img[112 +: 16] = 16'hBEEF;
    chk("wr writer", {out_bad_first_o, out_bus_first_o}, 17'h0BEEF);
    chk("wr reader", out_bad_second_o, 1'b1);
    bus(0, 4'h4, 32'h0);
    chk("status wr", rdat[2:0], 3'h4);
    bus(0, 4'h8, 32'h0);
    chk("conflicts", rdat, 32'h2);
    rnd = lfsr(rnd);
    bus(1, 4'h8, rnd);
    bus(0, 4'h8, 32'h0);
    chk("conflicts cleared", rdat, 32'h0);
    acc(1, 1, 0, 0, 14, 0);
    $display("test read clash done");
    bus(1, 4'h0, 32'h2);
    user_first.op(0, 0, 0, 3, 0);
    chk("inverted gate", out_bus_first_o, img[48 +: 16]);
    user_first.op(1, 0, 0, 4, 0);
    chk("inverted idle", out_bus_first_o, img[48 +: 16]);
    bus(1, 4'h0, 32'h4);
    user_first.op(1, 0, 0, 3, 16'h1234);
    img[48 +: 16] = 16'h1234;
    chk("inverted write", out_bus_first_o, 16'h1234);
    bus(1, 4'h0, 32'h0);
    acc(0, 1, 0, 0, 3, 0);
    $display("test polarity done");
    conclude();
  end
endmodule
bind tdp_ram tdp_ram_sva #(.WIDTH_FIRST(WIDTH_FIRST), .WIDTH_SECOND(WIDTH_SECOND)) tdp_ram_sva_inst (.*);

//--- verification/tdp_ram_sva.sv
// port and bus assertions of the dual-port memory
`timescale 1ns/100ps
module tdp_ram_sva #(
  parameter int WIDTH_FIRST = 16,
  parameter int WIDTH_SECOND = 16,
  localparam int AF = $clog2(4096 / WIDTH_FIRST),
  localparam int AS = $clog2(4096 / WIDTH_SECOND)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clock_first_i,
  input wire logic en_first_i,
  input wire logic we_first_i,
  input wire logic clr_first_i,
  input wire logic [AF-1:0] addr_first_i,
  input wire logic [WIDTH_FIRST-1:0] in_bus_first_i,
  input wire logic [WIDTH_FIRST-1:0] out_bus_first_o,
  input wire logic out_bad_first_o,
  input wire logic clock_second_i,
  input wire logic en_second_i,
  input wire logic we_second_i,
  input wire logic clr_second_i,
  input wire logic [AS-1:0] addr_second_i,
  input wire logic [WIDTH_SECOND-1:0] in_bus_second_i,
  input wire logic [WIDTH_SECOND-1:0] out_bus_second_o,
  input wire logic out_bad_second_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  logic [7:0] inv_q, inv_d;
  logic lf_q, ls_q, af, as, ov;
  // polarity follows bus writes, so checks stay right after inversion
  always_comb begin
    inv_d = inv_q;
    if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) begin
      inv_d = avs_writedata_i[7:0];
    end
    af = (clock_first_i ^ inv_q[0]) && !lf_q && (en_first_i ^ inv_q[1]);
    as = (clock_second_i ^ inv_q[4]) && !ls_q && (en_second_i ^ inv_q[5]);
    ov = int'(addr_first_i) * WIDTH_FIRST < int'(addr_second_i) * WIDTH_SECOND + WIDTH_SECOND
      && int'(addr_second_i) * WIDTH_SECOND < int'(addr_first_i) * WIDTH_FIRST + WIDTH_FIRST;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inv_q <= 8'h00;
      lf_q <= 1'b1;
      ls_q <= 1'b1;
    end else begin
      inv_q <= inv_d;
      lf_q <= clock_first_i ^ inv_q[0];
      ls_q <= clock_second_i ^ inv_q[4];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not a single cycle");
  a_shape_read: assert property (s_taken and avs_read_i && avs_address_i == 4'hC |=>
    avs_readdata_o == {16'h0000, 8'(WIDTH_SECOND), 8'(WIDTH_FIRST)})
    else $error("shape register wrong");
  a_hold_first: assert property (!af |=> $stable(out_bus_first_o))
    else $error("first output moved without access");
  a_hold_second: assert property (!as |=> $stable(out_bus_second_o))
    else $error("second output moved without access");
  a_mirror_first: assert property (af && (we_first_i ^ inv_q[2]) && !(clr_first_i ^ inv_q[3])
    |=> out_bus_first_o == $past(in_bus_first_i) && !out_bad_first_o)
    else $error("first write not mirrored");
  a_mirror_second: assert property (as && (we_second_i ^ inv_q[6]) && !(clr_second_i ^ inv_q[7])
    |=> out_bus_second_o == $past(in_bus_second_i) && !out_bad_second_o)
    else $error("second write not mirrored");
  a_clear_first: assert property (af && (clr_first_i ^ inv_q[3])
    |=> out_bus_first_o == '0 && !out_bad_first_o)
    else $error("first clear did not zero output");
  a_clash_reader: assert property (af && as && ov && (we_first_i ^ inv_q[2])
    && !(we_second_i ^ inv_q[6]) && !(clr_second_i ^ inv_q[7]) |=> out_bad_second_o)
    else $error("clashing read not flagged");
endmodule

//--- verification/tdp_user_port.sv
// user logic driving one memory port
`timescale 1ns/100ps
module tdp_user_port #(
  parameter int W = 16,
  parameter int AW = 8
) (
  input wire logic clk_i,
  output logic clock_o,
  output logic en_o,
  output logic we_o,
  output logic clr_o,
  output logic [AW-1:0] addr_o,
  output logic [W-1:0] din_o
);
  initial clock_o = 1'b0;
  initial {en_o, we_o, clr_o, addr_o, din_o} = '0;
  // one access per clock pulse; clashes only where the bench overlaps calls
  task automatic op(input logic e, w, c, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    clock_o <= 1'b1;
    {en_o, we_o, clr_o, addr_o, din_o} <= {e, w, c, a[AW-1:0], d[W-1:0]};
    @(posedge clk_i);
    clock_o <= 1'b0;
    // inverted off the edge so nothing leans on a stale value
    {en_o, we_o, clr_o, addr_o, din_o} <= ~{en_o, we_o, clr_o, addr_o, din_o};
    #1;
  endtask
endmodule
